// ===== rtl/dcirq_cfg_serial.sv
// Purpose: serial configuration port, one instruction byte and one data byte per access
// Assumes: serial clock slower than ref_clk / 8, mode 0, msb first
// Notes:   instruction bit 7 high means read, bits 4:0 hold the address
`timescale 1ns/10ps
module dcirq_cfg_serial (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       sys_rst,
  // serial pins
  input  wire logic                       ser_cs_n,
  input  wire logic                       ser_sclk,
  input  wire logic                       ser_sdi,
  output logic                            ser_sdo,
  output logic                            ser_sdo_oe,
  // register side
  output dcirq_pkg::dcirq_access_type     access,
  input  wire logic [7:0]                 rdata
);

  logic [2:0]                     pin_raw;
  logic [2:0]                     pin_filt;
  logic [2:0]                     pin_prev;
  logic                           sclk_rise;
  logic                           sclk_fall;
  logic                           cs_active;
  dcirq_pkg::dcirq_ser_state_type state;
  logic [2:0]                     bit_cnt;
  logic [7:0]                     in_shift;
  logic [7:0]                     next_shift;
  logic                           is_read;
  logic                           load_pend;
  logic [7:0]                     out_shift;

  assign pin_raw = {ser_cs_n, ser_sclk, ser_sdi};

  // three-stage synchroniser per pin, change taken when stages two and three agree
  for (genvar k = 0; k < 3; k++) begin : g_pin
    logic [dcirq_pkg::SYNC_DEPTH-1:0] q;
    logic                             f;
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        q <= 3'h7;
        f <= 1'h1;
      end else begin
        q <= {q[1:0], pin_raw[k]};
        if (q[1] == q[2]) begin
          f <= q[2];
        end
      end
    end
    assign pin_filt[k] = f;
  end

  // edge detect on the filtered levels
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_prev <= 3'h7;
    end else begin
      pin_prev <= pin_filt;
    end
  end

  assign sclk_rise  = pin_filt[1] & ~pin_prev[1];
  assign sclk_fall  = ~pin_filt[1] & pin_prev[1];
  assign cs_active  = ~pin_filt[2];
  assign next_shift = {in_shift[6:0], pin_filt[0]};

  // frame state, bit count and access strobes
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !cs_active) begin
      state    <= dcirq_pkg::SER_IDLE;
      bit_cnt  <= 3'h0;
      in_shift <= 8'h00;
      is_read  <= 1'h0;
      access   <= '0;
    end else begin
      access.wr <= 1'h0;
      access.rd <= 1'h0;
      case (state)
        dcirq_pkg::SER_IDLE: begin
          state   <= dcirq_pkg::SER_INSTR;
          bit_cnt <= 3'h0;
        end
        dcirq_pkg::SER_INSTR: begin
          if (sclk_rise) begin
            in_shift <= next_shift;
            bit_cnt  <= bit_cnt + 3'h1;
            if (bit_cnt == dcirq_pkg::LAST_BIT) begin
              is_read     <= next_shift[dcirq_pkg::BIT_READ_CMD];
              access.addr <= next_shift[4:0];
              access.rd   <= next_shift[dcirq_pkg::BIT_READ_CMD];
              state       <= dcirq_pkg::SER_DATA;
            end
          end
        end
        dcirq_pkg::SER_DATA: begin
          if (sclk_rise) begin
            in_shift <= next_shift;
            bit_cnt  <= bit_cnt + 3'h1;
            if (bit_cnt == dcirq_pkg::LAST_BIT) begin
              access.wdata <= next_shift;
              access.wr    <= ~is_read;
              state        <= dcirq_pkg::SER_IDLE;
            end
          end
        end
        default: state <= dcirq_pkg::SER_IDLE;
      endcase
    end
  end

  // read data out, shifted on falling serial clock after the first data bit
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      load_pend  <= 1'h0;
      out_shift  <= 8'h00;
      ser_sdo    <= 1'h0;
      ser_sdo_oe <= 1'h0;
    end else begin
      load_pend  <= access.rd;
      ser_sdo_oe <= cs_active && is_read && (state == dcirq_pkg::SER_DATA);
      if (load_pend) begin
        out_shift <= rdata;
        ser_sdo   <= rdata[7];
      end else if (sclk_fall && state == dcirq_pkg::SER_DATA && bit_cnt != 3'h0) begin
        out_shift <= {out_shift[6:0], 1'h0};
        ser_sdo   <= out_shift[6];
      end
    end
  end

endmodule // dcirq_cfg_serial

// ===== rtl/dcirq_regs.sv
// Purpose: control and status registers for the converter's controllers and output stage
// Assumes: controller lock levels on ref_clk, phase detector results asynchronous
// Notes:   registers reached only through the serial configuration port
//
// What this block does
// - six enable bits let each controller update its lock and unlock flags
// - writing an enable to zero clears its flag and blocks updates
// - lock flag shows locked; unlock flag shows the controller became unlocked
// - full-scale code is ten bits from two registers, low eight first
// - bit 7 of the high full-scale register puts the output to sleep
// - two-bit switch mode: baseband, return-to-zero or mix
// - early window flag: data clock edge before early phase-0 edge
// - late window flag: data clock edge before late phase-0 edge
// - sync input edge before phase-90 sampling edge sets flag
// - sync input edge before phase-0 sampling edge sets flag
// - writing one then zero to bit 7 clears sync controller flags
// - sync loop on: master lock loss raises interrupt and restarts search
// - bit 5 picks sync role, slave at reset
// - bit 4 enables the sync controller, off at reset
// - writing one then zero to bit 2 clears receiver flags
// - receiver loop on: lock loss raises interrupt and restarts search
// - bit 0 enables the receiver controller, off at reset
`timescale 1ns/10ps
module dcirq_regs (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  // serial configuration pins
  input  wire logic                   ser_cs_n,
  input  wire logic                   ser_sclk,
  input  wire logic                   ser_sdi,
  output logic                        ser_sdo,
  output logic                        ser_sdo_oe,
  // controller lock levels and phase detector results
  input  wire dcirq_pkg::dcirq_lock_type lock_state,
  input  wire logic [3:0]             phase_raw,
  // output stage control
  output logic [9:0]                  full_scale_code,
  output logic                        output_sleep,
  output logic [1:0]                  output_switch_mode_field,
  // sync controller control
  output logic                        sync_controller_on,
  output logic                        sync_role_select,
  output logic                        sync_auto_relock,
  output logic                        sync_flags_clear,
  output logic                        sync_restart,
  // data receiver controller control
  output logic                        receiver_controller_on,
  output logic                        receiver_auto_relock,
  output logic                        receiver_flags_clear,
  output logic                        receiver_restart,
  // controller interrupt request
  output logic                        controller_irq
);

  dcirq_pkg::dcirq_access_type acc;
  logic [7:0]                  rdata;
  logic [5:0]                  irq_en;
  logic [5:0]                  next_irq_en;
  logic [5:0]                  status;
  logic [5:0]                  clr_mask;
  logic [2:0]                  lock_now;
  logic [2:0]                  lock_prev;
  logic [7:0]                  scale_low;
  logic [1:0]                  scale_high;
  logic                        sync_clr_armed;
  logic                        rcv_clr_armed;
  logic [3:0]                  phase_flags;
  logic                        sync_irq;
  logic                        rcv_irq;
  logic                        sync_lost;
  logic                        rcv_lost;

  // address match, shared by the write and read paths
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] offset);
    hit = (addr == offset);
  endfunction

  // serial port engine
  dcirq_cfg_serial u_serial (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .ser_cs_n   (ser_cs_n),
    .ser_sclk   (ser_sclk),
    .ser_sdi    (ser_sdi),
    .ser_sdo    (ser_sdo),
    .ser_sdo_oe (ser_sdo_oe),
    .access     (acc),
    .rdata      (rdata)
  );

  // enable value seen by the flags in the same cycle as its write
  always_comb begin
    next_irq_en = irq_en;
    if (acc.wr && hit(acc.addr, dcirq_pkg::ADDR_IRQ_EN)) begin
      next_irq_en = acc.wdata[5:0];
    end
  end

  // write-only enable register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_en <= dcirq_pkg::RST_IRQ_EN;
    end else begin
      irq_en <= next_irq_en;
    end
  end

  // full-scale code and sleep
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      scale_low    <= dcirq_pkg::RST_SCALE_LOW;
      scale_high   <= dcirq_pkg::RST_SCALE_HIGH[1:0];
      output_sleep <= dcirq_pkg::RST_SCALE_HIGH[dcirq_pkg::BIT_SLEEP];
    end else if (acc.wr && hit(acc.addr, dcirq_pkg::ADDR_SCALE_LOW)) begin
      scale_low <= acc.wdata;
    end else if (acc.wr && hit(acc.addr, dcirq_pkg::ADDR_SCALE_HIGH)) begin
      scale_high   <= acc.wdata[1:0];
      output_sleep <= acc.wdata[dcirq_pkg::BIT_SLEEP];
    end
  end

  // output current is 0.0226 mA per code step above 8.58 mA
  assign full_scale_code = {scale_high, scale_low};

  // quad-switch mode, code 3 is stored but has no defined mode
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      output_switch_mode_field <= dcirq_pkg::RST_SW_MODE;
    end else if (acc.wr && hit(acc.addr, dcirq_pkg::ADDR_SW_MODE)) begin
      output_switch_mode_field <= acc.wdata[1:0];
    end
  end

  // controller configuration bits
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync_auto_relock       <= dcirq_pkg::RST_LOOP_ON;
      sync_role_select       <= 1'h0;
      sync_controller_on     <= 1'h0;
      receiver_auto_relock   <= dcirq_pkg::RST_LOOP_ON;
      receiver_controller_on <= 1'h0;
    end else if (acc.wr && hit(acc.addr, dcirq_pkg::ADDR_CTRL_CFG)) begin
      sync_auto_relock       <= acc.wdata[dcirq_pkg::BIT_SYNC_LOOP];
      sync_role_select       <= acc.wdata[dcirq_pkg::BIT_SYNC_ROLE];
      sync_controller_on     <= acc.wdata[dcirq_pkg::BIT_SYNC_ON];
      receiver_auto_relock   <= acc.wdata[dcirq_pkg::BIT_RCV_LOOP];
      receiver_controller_on <= acc.wdata[dcirq_pkg::BIT_RCV_ON];
    end
  end

  // flag clear: a write of one arms, the next write of zero fires one pulse
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync_clr_armed       <= 1'h0;
      rcv_clr_armed        <= 1'h0;
      sync_flags_clear     <= 1'h0;
      receiver_flags_clear <= 1'h0;
    end else begin
      sync_flags_clear     <= 1'h0;
      receiver_flags_clear <= 1'h0;
      if (acc.wr && hit(acc.addr, dcirq_pkg::ADDR_CTRL_CFG)) begin
        sync_clr_armed   <= acc.wdata[dcirq_pkg::BIT_SYNC_FLG_CLR];
        rcv_clr_armed    <= acc.wdata[dcirq_pkg::BIT_RCV_FLG_CLR];
        sync_flags_clear <= sync_clr_armed & ~acc.wdata[dcirq_pkg::BIT_SYNC_FLG_CLR];
        receiver_flags_clear <= rcv_clr_armed & ~acc.wdata[dcirq_pkg::BIT_RCV_FLG_CLR];
      end
    end
  end

  // lock history for loss detection
  assign lock_now = lock_state;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lock_prev <= 3'h0;
    end else begin
      lock_prev <= lock_now;
    end
  end

  // which flag pairs a clear pulse wipes
  assign clr_mask = {{2{sync_flags_clear}}, 2'h0, {2{receiver_flags_clear}}};

  // sticky lock and unlock flags, a set wins over a clear
  for (genvar i = 0; i < dcirq_pkg::NUM_CTL; i++) begin : g_flag
    logic set_lock;
    logic set_lost;
    assign set_lock = next_irq_en[2*i] & lock_now[i];
    assign set_lost = next_irq_en[2*i+1] & lock_prev[i] & ~lock_now[i];
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        status[2*i+1:2*i] <= 2'h0;
      end else begin
        if (!next_irq_en[2*i]) begin
          status[2*i] <= 1'h0;
        end else if (set_lock) begin
          status[2*i] <= 1'h1;
        end else if (clr_mask[2*i]) begin
          status[2*i] <= 1'h0;
        end
        if (!next_irq_en[2*i+1]) begin
          status[2*i+1] <= 1'h0;
        end else if (set_lost) begin
          status[2*i+1] <= 1'h1;
        end else if (clr_mask[2*i+1]) begin
          status[2*i+1] <= 1'h0;
        end
      end
    end
  end

  // lock loss that starts an automatic relock
  assign sync_lost = lock_prev[dcirq_pkg::CTL_SYNC] & ~lock_now[dcirq_pkg::CTL_SYNC];
  assign rcv_lost  = lock_prev[dcirq_pkg::CTL_RECV] & ~lock_now[dcirq_pkg::CTL_RECV];

  // restart pulses and interrupt latches; a new loss wins over a clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync_restart     <= 1'h0;
      receiver_restart <= 1'h0;
      sync_irq         <= 1'h0;
      rcv_irq          <= 1'h0;
    end else begin
      sync_restart <= sync_lost & sync_auto_relock & sync_role_select
                      & sync_controller_on;
      receiver_restart <= rcv_lost & receiver_auto_relock & receiver_controller_on;
      if (sync_lost && sync_auto_relock && sync_role_select && sync_controller_on) begin
        sync_irq <= 1'h1;
      end else if (sync_flags_clear) begin
        sync_irq <= 1'h0;
      end
      if (rcv_lost && receiver_auto_relock && receiver_controller_on) begin
        rcv_irq <= 1'h1;
      end else if (receiver_flags_clear) begin
        rcv_irq <= 1'h0;
      end
    end
  end

  // interrupt output
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      controller_irq <= 1'h0;
    end else begin
      controller_irq <= sync_irq | rcv_irq;
    end
  end

  // phase detector results, three flops each, taken when stages two and three agree
  for (genvar p = 0; p < dcirq_pkg::NUM_PH; p++) begin : g_phase
    logic [dcirq_pkg::SYNC_DEPTH-1:0] q;
    logic                             f;
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        q <= 3'h0;
        f <= 1'h0;
      end else begin
        q <= {q[1:0], phase_raw[p]};
        if (q[1] == q[2]) begin
          f <= q[2];
        end
      end
    end
    assign phase_flags[p] = f;
  end

  // read mux; write-only bits and unmapped addresses read zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= 8'h00;
      if (hit(acc.addr, dcirq_pkg::ADDR_IRQ_STATUS)) begin
        rdata <= {2'h0, status};
      end else if (hit(acc.addr, dcirq_pkg::ADDR_SCALE_LOW)) begin
        rdata <= scale_low;
      end else if (hit(acc.addr, dcirq_pkg::ADDR_SCALE_HIGH)) begin
        rdata <= {output_sleep, 5'h00, scale_high};
      end else if (hit(acc.addr, dcirq_pkg::ADDR_SW_MODE)) begin
        rdata <= {6'h00, output_switch_mode_field};
      end else if (hit(acc.addr, dcirq_pkg::ADDR_DCLK_PHASE)) begin
        rdata[dcirq_pkg::BIT_DCLK_EARLY] <= phase_flags[dcirq_pkg::PH_EARLY];
        rdata[dcirq_pkg::BIT_DCLK_LATE]  <= phase_flags[dcirq_pkg::PH_LATE];
      end else if (hit(acc.addr, dcirq_pkg::ADDR_SYNC_PHASE)) begin
        rdata[dcirq_pkg::BIT_SYNC_Q90] <= phase_flags[dcirq_pkg::PH_Q90];
        rdata[dcirq_pkg::BIT_SYNC_Q0]  <= phase_flags[dcirq_pkg::PH_Q0];
      end else if (hit(acc.addr, dcirq_pkg::ADDR_CTRL_CFG)) begin
        rdata <= {1'h0, sync_auto_relock, sync_role_select, sync_controller_on,
                  2'h0, receiver_auto_relock, receiver_controller_on};
      end
    end
  end

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  a_status_gated_enable: assert property ((status & ~irq_en) == 6'h00)
    else $error("status flag set while its enable is zero");

  a_lock_flag_sets: assert property (next_irq_en[0] && lock_now[0] |=> status[0])
    else $error("receiver lock flag not set while locked and enabled");

  a_unlock_flag_sets: assert property (
    next_irq_en[5] && $fell(lock_now[2]) |=> status[5])
    else $error("sync unlock flag missed a lock loss");

  a_flag_stays_set: assert property (
    status[3] && next_irq_en[3] |=> status[3])
    else $error("delay lock unlock flag dropped without a disable");

  a_scale_low_write: assert property (
    acc.wr && acc.addr == dcirq_pkg::ADDR_SCALE_LOW
    |=> full_scale_code[7:0] == $past(acc.wdata) && $stable(full_scale_code[9:8]))
    else $error("full-scale low byte not taken");

  a_sleep_write: assert property (
    acc.wr && acc.addr == dcirq_pkg::ADDR_SCALE_HIGH
    |=> output_sleep == $past(acc.wdata[7]) && full_scale_code[9:8] == $past(acc.wdata[1:0]))
    else $error("sleep or high full-scale bits not taken");

  a_mode_write: assert property (
    acc.wr && acc.addr == dcirq_pkg::ADDR_SW_MODE
    |=> output_switch_mode_field == $past(acc.wdata[1:0]))
    else $error("switch mode not taken");

  a_sync_clear_seq: assert property (
    sync_flags_clear |-> $past(sync_clr_armed) && !sync_clr_armed ##1 !sync_flags_clear)
    else $error("sync flag clear without one then zero");

  a_rcv_clear_wipes: assert property (
    receiver_flags_clear && !lock_now[0] && !lock_prev[0] |=> status[1:0] == 2'h0)
    else $error("receiver flags survive a clear");

  a_sync_restart_cause: assert property (
    sync_restart |-> $past(sync_lost) && $past(sync_role_select) && sync_irq ##1 controller_irq)
    else $error("sync restart without master lock loss or no interrupt");

  a_rcv_restart_cause: assert property (
    rcv_lost && receiver_auto_relock && receiver_controller_on |=> receiver_restart ##1 controller_irq)
    else $error("receiver lock loss did not restart and interrupt");

  a_phase_settled: assert property (
    !$stable(phase_flags[dcirq_pkg::PH_EARLY]) |-> $past(g_phase[1].q[2]) == $past(g_phase[1].q[1]))
    else $error("phase flag changed before synchroniser settled");

endmodule // dcirq_regs

// ===== shared/dcirq_pkg.sv
// Purpose: constants and types for the converter control and status register group
// Assumes: 5-bit register addresses, 8-bit register data
// Notes:   one serial frame carries one instruction byte and one data byte
package dcirq_pkg;

  // register offsets
  localparam logic [4:0] ADDR_IRQ_EN     = 5'h03;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h04;
  localparam logic [4:0] ADDR_SCALE_LOW  = 5'h06;
  localparam logic [4:0] ADDR_SCALE_HIGH = 5'h07;
  localparam logic [4:0] ADDR_SW_MODE    = 5'h08;
  localparam logic [4:0] ADDR_DCLK_PHASE = 5'h0C;
  localparam logic [4:0] ADDR_SYNC_PHASE = 5'h0D;
  localparam logic [4:0] ADDR_CTRL_CFG   = 5'h10;

  // reset values
  localparam logic [7:0] RST_SCALE_LOW  = 8'h00;
  localparam logic [7:0] RST_SCALE_HIGH = 8'h02;
  localparam logic [1:0] RST_SW_MODE    = 2'h0;
  localparam logic [5:0] RST_IRQ_EN     = 6'h00;
  localparam logic       RST_LOOP_ON    = 1'h1;

  // field positions
  localparam int BIT_SLEEP        = 7;
  localparam int BIT_SYNC_FLG_CLR = 7;
  localparam int BIT_SYNC_LOOP    = 6;
  localparam int BIT_SYNC_ROLE    = 5;
  localparam int BIT_SYNC_ON      = 4;
  localparam int BIT_RCV_FLG_CLR  = 2;
  localparam int BIT_RCV_LOOP     = 1;
  localparam int BIT_RCV_ON       = 0;
  localparam int BIT_DCLK_EARLY   = 2;
  localparam int BIT_DCLK_LATE    = 0;
  localparam int BIT_SYNC_Q90     = 5;
  localparam int BIT_SYNC_Q0      = 4;
  localparam int BIT_READ_CMD     = 7;

  // controller index: lock flag at 2*i, unlock flag at 2*i+1
  localparam int CTL_RECV  = 0;
  localparam int CTL_DELAY = 1;
  localparam int CTL_SYNC  = 2;
  localparam int NUM_CTL   = 3;

  // phase detector result index
  localparam int PH_LATE  = 0;
  localparam int PH_EARLY = 1;
  localparam int PH_Q0    = 2;
  localparam int PH_Q90   = 3;
  localparam int NUM_PH   = 4;

  // output switch modes
  localparam logic [1:0] MODE_BASEBAND = 2'h0;
  localparam logic [1:0] MODE_RZ       = 2'h1;
  localparam logic [1:0] MODE_MIX      = 2'h2;

  // last bit index of a serial byte, pin synchroniser depth
  localparam logic [2:0] LAST_BIT   = 3'h7;
  localparam int         SYNC_DEPTH = 3;

  typedef enum logic [2:0] {
    SER_IDLE  = 3'b001,
    SER_INSTR = 3'b010,
    SER_DATA  = 3'b100
  } dcirq_ser_state_type;

  // one register access from the serial port
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dcirq_access_type;

  // lock levels of the three controllers
  typedef struct packed {
    logic sync;
    logic delay;
    logic recv;
  } dcirq_lock_type;

endpackage

// ===== tb/dcirq_regs_tb.sv
// Purpose: self-checking bench for the control and status register group
// Assumes: serial port driven at ref_clk / 12, inputs driven 2 ns after rising edge
// Notes:   every wait is a fixed cycle count, so no run can hang
`timescale 1ns/10ps
module dcirq_regs_tb;
  logic                     ref_clk = 1'b0;
  logic                     sys_rst = 1'b1;
  logic                     ser_cs_n = 1'b1;
  logic                     ser_sclk = 1'b1;
  logic                     ser_sdi = 1'b0;
  logic                     ser_sdo, ser_sdo_oe;
  dcirq_pkg::dcirq_lock_type lock_state = '0;
  logic [3:0]               phase_raw = 4'h0;
  logic [9:0]               full_scale_code;
  logic                     output_sleep, sync_controller_on, sync_role_select, sync_auto_relock;
  logic                     sync_flags_clear, sync_restart, receiver_controller_on;
  logic                     receiver_auto_relock, receiver_flags_clear, receiver_restart;
  logic [1:0]               output_switch_mode_field;
  logic                     controller_irq;
  logic [7:0]               rd;
  int                       bad_count = 0;
  int                       total_checks = 0;
  int                       n_srst = 0, n_rrst = 0, n_sclr = 0, n_rclr = 0, n_oe = 0;

  dcirq_regs u_dcirq_regs (.ref_clk(ref_clk), .sys_rst(sys_rst), .ser_cs_n(ser_cs_n),
    .ser_sclk(ser_sclk), .ser_sdi(ser_sdi), .ser_sdo(ser_sdo), .ser_sdo_oe(ser_sdo_oe),
    .lock_state(lock_state), .phase_raw(phase_raw), .full_scale_code(full_scale_code),
    .output_sleep(output_sleep), .output_switch_mode_field(output_switch_mode_field),
    .sync_controller_on(sync_controller_on), .sync_role_select(sync_role_select),
    .sync_auto_relock(sync_auto_relock), .sync_flags_clear(sync_flags_clear),
    .sync_restart(sync_restart), .receiver_controller_on(receiver_controller_on),
    .receiver_auto_relock(receiver_auto_relock), .receiver_flags_clear(receiver_flags_clear),
    .receiver_restart(receiver_restart), .controller_irq(controller_irq));

  // 40 MHz reference clock
  always #12.5 ref_clk = ~ref_clk;

  // count one-cycle pulses and cycles with read data driven
  always @(posedge ref_clk) begin
    n_srst += sync_restart;
    n_rrst += receiver_restart;
    n_sclr += sync_flags_clear;
    n_rclr += receiver_flags_clear;
    n_oe   += ser_sdo_oe;
  end

  // wait n edges, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  // one frame: instruction byte then data byte, msb first, sdo sampled before each data byte rise
  task automatic xfer(input logic [7:0] ins, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] w;
    w = {ins, d};
    q = 8'h00;
    ser_cs_n = 1'b0;
    ser_sclk = 1'b0;
    cyc(6);
    for (int i = 15; i >= 0; i--) begin
      ser_sdi = w[i];
      cyc(6);
      if (i < 8) q[i] = ser_sdo;
      ser_sclk = 1'b1;
      cyc(6);
      if (i > 0) ser_sclk = 1'b0;
    end
    cyc(6);
    ser_cs_n = 1'b1;
    cyc(10);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer({3'h0, a}, d, q);
  endtask

  task automatic rdr(input logic [4:0] a, output logic [7:0] q);
    xfer({3'h4, a}, 8'h00, q);
  endtask

  // compare one value, report and count
  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    cyc(4);
    sys_rst = 1'b0;
    cyc(6);
    // reset values
    chk("scale_rst", 10'h200, full_scale_code);
    chk("relock_rst", 10'h3, {sync_auto_relock, receiver_auto_relock});
    chk("on_rst", 10'h0, {sync_controller_on, sync_role_select, receiver_controller_on});
    // full-scale code from two registers and sleep
    wr(dcirq_pkg::ADDR_SCALE_LOW, 8'hA5);
    wr(dcirq_pkg::ADDR_SCALE_HIGH, 8'h83);
    chk("scale", 10'h3A5, full_scale_code);
    chk("sleep", 10'h1, output_sleep);
    chk("oe_on_write", 10'h0, 10'(n_oe));
    rdr(dcirq_pkg::ADDR_SCALE_HIGH, rd);
    chk("scale_high_rd", 10'h83, rd);
    chk("oe_on_read", 10'h1, 10'(n_oe != 0));
    chk("oe_idle", 10'h0, ser_sdo_oe);
    // every switching mode
    for (int m = 0; m < 3; m++) begin
      wr(dcirq_pkg::ADDR_SW_MODE, 8'(m));
      chk("mode", 10'(m), output_switch_mode_field);
    end
    // phase detector flags
    phase_raw = 4'hA;
    cyc(8);
    rdr(dcirq_pkg::ADDR_DCLK_PHASE, rd);
    chk("dclk_phase", 10'h04, rd);
    rdr(dcirq_pkg::ADDR_SYNC_PHASE, rd);
    chk("sync_phase", 10'h20, rd);
    phase_raw = 4'h5;
    cyc(8);
    rdr(dcirq_pkg::ADDR_DCLK_PHASE, rd);
    chk("dclk_phase2", 10'h01, rd);
    rdr(dcirq_pkg::ADDR_SYNC_PHASE, rd);
    chk("sync_phase2", 10'h10, rd);
    // unmapped address read
    rdr(5'h1F, rd);
    chk("unmapped", 10'h00, rd);
    // status flags before enables: no update
    lock_state = 3'h7;
    cyc(4);
    rdr(dcirq_pkg::ADDR_IRQ_STATUS, rd);
    chk("status_off", 10'h00, rd);
    wr(dcirq_pkg::ADDR_IRQ_EN, 8'h3F);
    wr(dcirq_pkg::ADDR_CTRL_CFG, 8'h77);
    chk("ctrl_out", 10'h1F, {sync_auto_relock, sync_role_select, sync_controller_on,
      receiver_auto_relock, receiver_controller_on});
    rdr(dcirq_pkg::ADDR_CTRL_CFG, rd);
    chk("cfg_rd", 10'h73, rd);
    rdr(dcirq_pkg::ADDR_IRQ_EN, rd);
    chk("en_rd", 10'h00, rd);
    rdr(dcirq_pkg::ADDR_IRQ_STATUS, rd);
    chk("status_lock", 10'h15, rd);
    // lock loss: unlock flags set, lock flags held, interrupt raised
    lock_state = 3'h0;
    cyc(4);
    chk("irq", 10'h1, controller_irq);
    rdr(dcirq_pkg::ADDR_IRQ_STATUS, rd);
    chk("status_lost", 10'h3F, rd);
    chk("sync_restart", 10'h1, 10'(n_srst));
    chk("rcv_restart", 10'h1, 10'(n_rrst));
    // receiver flag clear: second write of bit 2 low
    wr(dcirq_pkg::ADDR_CTRL_CFG, 8'h73);
    rdr(dcirq_pkg::ADDR_IRQ_STATUS, rd);
    chk("rcv_clr", 10'h3C, rd);
    chk("rcv_clr_pulse", 10'h1, 10'(n_rclr));
    chk("irq_sync", 10'h1, controller_irq);
    wr(dcirq_pkg::ADDR_CTRL_CFG, 8'hF3);
    wr(dcirq_pkg::ADDR_CTRL_CFG, 8'h73);
    rdr(dcirq_pkg::ADDR_IRQ_STATUS, rd);
    chk("sync_clr", 10'h0C, rd);
    chk("sync_clr_pulse", 10'h1, 10'(n_sclr));
    chk("irq_clr", 10'h0, controller_irq);
    // writing enables to zero clears and blocks flags
    wr(dcirq_pkg::ADDR_IRQ_EN, 8'h00);
    lock_state = 3'h7;
    cyc(4);
    rdr(dcirq_pkg::ADDR_IRQ_STATUS, rd);
    chk("en_zero", 10'h00, rd);
    wr(dcirq_pkg::ADDR_IRQ_EN, 8'h3F);
    rdr(dcirq_pkg::ADDR_IRQ_STATUS, rd);
    chk("rearm", 10'h15, rd);
    test_done();
  end
endmodule // dcirq_regs_tb
